/* core/bcast_pkg.sv */
// constants and field layout of the periodic status broadcast framer
// Summary of operation
// - frames use 29-bit parameter-group identifiers for a 250 kb/s CAN link
// - broadcast only while option enabled and engine selection matches
// - every broadcast frame carries identifier priority 3, never altered
// - parameters not implemented are sent with all bits set to one
// - multi-byte values send most significant byte first, in byte 1
// - switching status group: page 0/0, PF FD, PS 91, 8 bytes, 250 ms
// - byte 1 bits 1-3: generator breaker open/closed/locked/error/n.a.
// - byte 1 bits 4-6: utility breaker, same codes, 011-101 never sent
// - control group: page 0/0, PF FD, PS 93, 8 bytes, 100 ms
// - control byte 1 bits 4-5: automatic start ready/not ready/error/n.a.
package bcast_pkg;
    localparam logic [2:0] ID_PRIO = 3'h3;
    localparam logic ID_EDP = 1'h0;
    localparam logic ID_DP = 1'h0;
    localparam logic [7:0] PF_PROP = 8'hFD;
    localparam logic [7:0] PS_ACS = 8'h91;
    localparam logic [7:0] PS_GC1 = 8'h93;
    localparam int PGN_ACS = 64913;
    localparam int PGN_GC1 = 64915;
    // arbitrary source address, set per installation
    localparam logic [7:0] SRC_ADDR_DEF = 8'h80;
    localparam logic [3:0] FRAME_DLC = 4'h8;
    localparam int BIT_RATE_KBPS = 250;

    // byte 1 sits in data[63:56]; bit 1 of a byte is its lsb
    localparam int BYTE1_LSB = 56;
    localparam int BRK_GEN_LSB = 56;
    localparam int BRK_UTIL_LSB = 59;
    localparam int AUTO_LSB = 59;
    localparam logic [55:0] FILL_ONES = 56'hFF_FFFF_FFFF_FFFF;

    localparam logic [2:0] BRK_OPEN = 3'h0;
    localparam logic [2:0] BRK_CLOSED = 3'h1;
    localparam logic [2:0] BRK_LOCKED = 3'h2;
    localparam logic [2:0] BRK_ERROR = 3'h6;
    localparam logic [2:0] BRK_NA = 3'h7;
    localparam logic [1:0] AUTO_READY = 2'h0;
    localparam logic [1:0] AUTO_NOT_READY = 2'h1;
    localparam logic [1:0] AUTO_ERROR = 2'h2;
    localparam logic [1:0] AUTO_NA = 2'h3;

    localparam int CLK_HZ = 25_000_000;
    localparam int ACS_PERIOD_MS = 250;
    localparam int GC1_PERIOD_MS = 100;
    localparam int ACS_PERIOD_CYC = (CLK_HZ / 1000) * ACS_PERIOD_MS;
    localparam int GC1_PERIOD_CYC = (CLK_HZ / 1000) * GC1_PERIOD_MS;
    localparam int TMR_W = 23;
endpackage

/* core/j1939_status_broadcast.sv */
// periodic status and control frame builder with two-entry output buffer
`timescale 1ns/1ps
module j1939_status_broadcast #(
    parameter int ACS_CYCLES = bcast_pkg::ACS_PERIOD_CYC,
    parameter int GC1_CYCLES = bcast_pkg::GC1_PERIOD_CYC,
    parameter logic [7:0] SRC_ADDR = bcast_pkg::SRC_ADDR_DEF
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic bcast_en,
    input wire logic engine_sel_ok,
    input wire logic [2:0] gen_brk_state,
    input wire logic [2:0] util_brk_state,
    input wire logic [1:0] autostart_state,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [28:0] tx_id,
    output logic [3:0] tx_dlc,
    output logic [63:0] tx_data
);
    import bcast_pkg::*;

    // reserved codes are never sent; report them as a breaker error
    function automatic logic [2:0] brk_code(input logic [2:0] s);
        if (s == BRK_OPEN || s == BRK_CLOSED || s == BRK_LOCKED ||
            s == BRK_ERROR || s == BRK_NA) begin
            return s;
        end
        return BRK_ERROR;
    endfunction

    function automatic logic [28:0] build_id(input logic [7:0] ps);
        return {ID_PRIO, ID_EDP, ID_DP, PF_PROP, ps, SRC_ADDR};
    endfunction

    function automatic logic is_group(input logic [28:0] id,
                                      input logic [7:0] ps);
        return id[23:16] == PF_PROP && id[15:8] == ps;
    endfunction

    logic bcast_on;
    logic [1:0] pend_ff;
    logic [1:0] grant;
    logic push;
    logic pop;
    logic [28:0] nxt_id;
    logic [63:0] nxt_data;
    logic head_vld_ff;
    logic [28:0] head_id_ff;
    logic [63:0] head_data_ff;
    logic skid_vld_ff;
    logic [28:0] skid_id_ff;
    logic [63:0] skid_data_ff;
    logic [3:0] dlc_ff;

    assign bcast_on = bcast_en & engine_sel_ok;

    // one period timer per group; held at zero while broadcasting is off
    for (genvar g = 0; g < 2; g++) begin : g_tmr
        localparam logic [TMR_W-1:0] LIM =
            TMR_W'((g == 0 ? ACS_CYCLES : GC1_CYCLES) - 1);
        logic [TMR_W-1:0] cnt_ff;

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt_ff <= '0;
            end else if (!bcast_on || cnt_ff == LIM) begin
                cnt_ff <= '0;
            end else begin
                cnt_ff <= cnt_ff + TMR_W'(1);
            end
        end

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                pend_ff[g] <= 1'b0;
            end else if (!bcast_on) begin
                pend_ff[g] <= 1'b0;
            end else if (cnt_ff == LIM) begin
                pend_ff[g] <= 1'b1;
            end else if (grant[g]) begin
                pend_ff[g] <= 1'b0;
            end
        end
    end

    // faster group wins a tie so its tighter period holds
    assign push = bcast_on && !skid_vld_ff && (pend_ff != 2'b00);
    assign grant[1] = push && pend_ff[1];
    assign grant[0] = push && !pend_ff[1] && pend_ff[0];
    assign pop = head_vld_ff && tx_ready;

    always_comb begin
        if (grant[1]) begin
            nxt_id = build_id(PS_GC1);
            nxt_data = {3'b111, autostart_state, 3'b111, FILL_ONES};
        end else begin
            nxt_id = build_id(PS_ACS);
            nxt_data = {2'b11, brk_code(util_brk_state),
                        brk_code(gen_brk_state), FILL_ONES};
        end
    end

    // head slot feeds the pins; skid slot absorbs one word during a stall
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            head_vld_ff <= 1'b0;
            head_id_ff <= '0;
            head_data_ff <= '0;
        end else if (!bcast_on) begin
            head_vld_ff <= 1'b0;
        end else if (!head_vld_ff || pop) begin
            if (skid_vld_ff) begin
                head_vld_ff <= 1'b1;
                head_id_ff <= skid_id_ff;
                head_data_ff <= skid_data_ff;
            end else if (push) begin
                head_vld_ff <= 1'b1;
                head_id_ff <= nxt_id;
                head_data_ff <= nxt_data;
            end else begin
                head_vld_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            skid_vld_ff <= 1'b0;
            skid_id_ff <= '0;
            skid_data_ff <= '0;
        end else if (!bcast_on) begin
            skid_vld_ff <= 1'b0;
        end else if (push && (skid_vld_ff || (head_vld_ff && !pop))) begin
            skid_vld_ff <= 1'b1;
            skid_id_ff <= nxt_id;
            skid_data_ff <= nxt_data;
        end else if (!head_vld_ff || pop) begin
            skid_vld_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dlc_ff <= FRAME_DLC;
        end else begin
            dlc_ff <= FRAME_DLC;
        end
    end

    assign tx_valid = head_vld_ff;
    assign tx_id = head_id_ff;
    assign tx_data = head_data_ff;
    assign tx_dlc = dlc_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic acs_out;
    logic gc1_out;
    assign acs_out = tx_valid && is_group(tx_id, PS_ACS);
    assign gc1_out = tx_valid && is_group(tx_id, PS_GC1);
    logic acs_load;
    logic gc1_load;
    assign acs_load = grant[0] && (!head_vld_ff || pop);
    assign gc1_load = grant[1] && (!head_vld_ff || pop);

    a_prio_fixed: assert property (tx_valid |-> tx_id[28:26] == 3'h3)
        else $error("frame priority not 3");
    a_off_silent: assert property (!bcast_on |=> !tx_valid)
        else $error("frame offered while broadcast disabled");
    a_acs_ident: assert property (acs_out |->
        tx_id[25:8] == 18'(PGN_ACS) && tx_dlc == 4'h8)
        else $error("switching status identifier or length wrong");
    a_gc1_ident: assert property (gc1_out |->
        tx_id[25:8] == 18'(PGN_GC1) && tx_dlc == 4'h8)
        else $error("control identifier or length wrong");
    a_gen_code: assert property (acs_out |->
        !(tx_data[58:56] inside {3'h3, 3'h4, 3'h5}))
        else $error("reserved generator breaker code sent");
    a_util_code: assert property (acs_out |->
        !(tx_data[61:59] inside {3'h3, 3'h4, 3'h5}))
        else $error("reserved utility breaker code sent");
    a_acs_fill: assert property (acs_out |->
        tx_data[63:62] == 2'b11 && tx_data[55:0] == FILL_ONES)
        else $error("unused switching status bits not ones");
    a_gc1_fill: assert property (gc1_out |->
        tx_data[63:61] == 3'b111 && tx_data[58:0] == {3'b111, FILL_ONES})
        else $error("unused control bits not ones");
    a_stall_hold: assert property (tx_valid && !tx_ready && bcast_on
        |=> tx_valid && $stable(tx_id) && $stable(tx_data))
        else $error("word changed under stall");

    a_gen_pass: assert property (acs_load &&
        !(gen_brk_state inside {3'h3, 3'h4, 3'h5})
        |=> tx_data[58:56] == $past(gen_brk_state))
        else $error("generator breaker code not carried");
    a_util_pass: assert property (acs_load &&
        !(util_brk_state inside {3'h3, 3'h4, 3'h5})
        |=> tx_data[61:59] == $past(util_brk_state))
        else $error("utility breaker code not carried");
    // reserved inputs must leave as the error code
    a_gen_resv: assert property (acs_load &&
        gen_brk_state inside {3'h3, 3'h4, 3'h5} |=> tx_data[58:56] == 3'h6)
        else $error("reserved generator input not sent as error");
    a_util_resv: assert property (acs_load &&
        util_brk_state inside {3'h3, 3'h4, 3'h5} |=> tx_data[61:59] == 3'h6)
        else $error("reserved utility input not sent as error");
    a_auto_pass: assert property (gc1_load |=>
        tx_data[60:59] == $past(autostart_state))
        else $error("readiness code not carried");

    c_acs_sent: cover property (acs_out && tx_ready);
    c_gc1_sent: cover property (gc1_out && tx_ready);
    c_buf_full: cover property (head_vld_ff && skid_vld_ff && !tx_ready);
    c_tie: cover property (pend_ff == 2'b11 && push);
    c_flush: cover property (tx_valid && !bcast_on);
endmodule

/* verif/can_sink.sv */
// sink model of the can controller taking framer words
`timescale 1ns/1ps
module can_sink (
    input wire logic core_clk,
    input wire logic stall,
    input wire logic tx_valid,
    input wire logic [28:0] tx_id,
    input wire logic [3:0] tx_dlc,
    input wire logic [63:0] tx_data,
    output logic tx_ready,
    output logic got,
    output logic [28:0] got_id,
    output logic [3:0] got_dlc,
    output logic [63:0] got_data
);
    // follows the bench stall, so it moves off the sampling edge
    assign tx_ready = !stall;
    always @(posedge core_clk) begin
        got <= tx_valid && tx_ready;
        got_id <= tx_id;
        got_dlc <= tx_dlc;
        got_data <= tx_data;
    end
endmodule

/* verif/j1939_status_broadcast_tb.sv */
// self-checking bench of the status broadcast framer
`timescale 1ns/1ps
`define CHK(a, b) chk_eq((a) !== (b));
module j1939_status_broadcast_tb;
    import bcast_pkg::*;
    // short periods keep the run brief
    localparam int ACS_N = 50;
    localparam int GC1_N = 20;
    localparam logic [7:0] SA = 8'h5a;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic bcast_en = 1'b0;
    logic engine_sel_ok = 1'b0;
    logic [2:0] gen_brk_state = 3'h0;
    logic [2:0] util_brk_state = 3'h0;
    logic [1:0] autostart_state = 2'h0;
    logic stall = 1'b0;
    logic tx_ready, tx_valid, got;
    logic [28:0] tx_id, got_id, w_id;
    logic [3:0] tx_dlc, got_dlc;
    logic [63:0] tx_data, got_data;
    int cyc = 0;
    int failures = 0;
    int n_checks = 0;
    int w_t, last_gc, last_acs, t_on;
    j1939_status_broadcast #(
        .ACS_CYCLES(ACS_N), .GC1_CYCLES(GC1_N), .SRC_ADDR(SA)
    ) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .bcast_en(bcast_en),
        .engine_sel_ok(engine_sel_ok), .gen_brk_state(gen_brk_state),
        .util_brk_state(util_brk_state), .autostart_state(autostart_state),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_id(tx_id),
        .tx_dlc(tx_dlc), .tx_data(tx_data)
    );
    can_sink u_sink (
        .core_clk(core_clk), .stall(stall), .tx_valid(tx_valid),
        .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data),
        .tx_ready(tx_ready), .got(got), .got_id(got_id),
        .got_dlc(got_dlc), .got_data(got_data)
    );
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            test_done();
        end
    end
    task automatic chk_eq(input logic bad);
        n_checks++;
        if (bad) begin
            failures++;
            $display("ERROR %0t: value mismatch", $time);
        end
    endtask
    task automatic test_done();
        if (failures == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // reserved breaker codes go out as error
    function automatic logic [2:0] brk(input logic [2:0] c);
        return (c inside {3'h3, 3'h4, 3'h5}) ? BRK_ERROR : c;
    endfunction
    task automatic get_word();
        int k;
        logic [7:0] b1;
        k = 0;
        while (got !== 1'b1 && k < 200) begin
            @(negedge core_clk);
            k++;
        end
        w_id = got_id;
        w_t = cyc;
        b1 = {2'h3, brk(util_brk_state), brk(gen_brk_state)};
        if (w_id[15:8] === PS_GC1) b1 = {3'h7, autostart_state, 3'h7};
        `CHK(got, 1'b1)
        `CHK(w_id[28:16], {ID_PRIO, ID_EDP, ID_DP, PF_PROP})
        `CHK(w_id[15:8] inside {PS_ACS, PS_GC1}, 1'b1)
        `CHK(w_id[7:0], SA)
        `CHK(got_dlc, FRAME_DLC)
        `CHK(got_data, {b1, FILL_ONES})
        @(negedge core_clk);
    endtask
    task automatic t_off();
        for (int i = 0; i < 2; i++) begin
            bcast_en = i[0];
            engine_sel_ok = !i[0];
            repeat (60) begin
                @(negedge core_clk);
                `CHK(tx_valid, 1'b0)
            end
        end
    endtask
    task automatic t_codes();
        int rel;
        bcast_en = 1'b1;
        engine_sel_ok = 1'b1;
        t_on = cyc;
        for (int c = 0; c < 8; c++) begin
            gen_brk_state = c[2:0];
            util_brk_state = 3'h7 - c[2:0];
            autostart_state = c[1:0];
            do begin
                get_word();
                if (w_id[15:8] === PS_GC1 && last_gc > 0) begin
                    `CHK(w_t - last_gc, GC1_N)
                end
                if (w_id[15:8] === PS_ACS && last_acs > 0) begin
                    // a tie with the control group costs one cycle
                    rel = w_t - t_on - 2;
                    `CHK(rel % ACS_N, (rel / ACS_N * ACS_N) % GC1_N == 0)
                end
                if (w_id[15:8] === PS_GC1) last_gc = w_t;
            end while (w_id[15:8] !== PS_ACS);
            last_acs = w_t;
        end
    endtask
    task automatic t_stall();
        logic [28:0] head;
        stall = 1'b1;
        repeat (30) @(negedge core_clk);
        head = tx_id;
        repeat (100) @(negedge core_clk);
        `CHK(tx_valid, 1'b1)
        `CHK(tx_id, head)
        stall = 1'b0;
        repeat (3) get_word();
    endtask
    task automatic t_flush();
        stall = 1'b1;
        repeat (25) @(negedge core_clk);
        `CHK(tx_valid, 1'b1)
        bcast_en = 1'b0;
        @(negedge core_clk);
        `CHK(tx_valid, 1'b0)
    endtask
    initial begin
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        t_off();
        t_codes();
        t_stall();
        t_flush();
        test_done();
    end
endmodule
